/* core/swc_switch_ctrl_fn.sv */
// Contract
// - Start-of-movement time 0..60 s, default 100 ms
// - Intermediate time 0..60 s, default 150 ms
// - Separate open/close pulse lengths, default 200 ms
// - Early release ends pulse at new position
// - Mid-position hidden while intermediate timer runs
// - Local selector rejects all internal commands
// - Remote selector accepts internal commands
// - Open inhibit refuses opens, shows open-inhibited
// - Close inhibit refuses closes, shows close-inhibited
// - Update inhibit freezes position, resets related outputs
// - Function block: no outputs, commands rejected
// - Inhibit indications registered from inputs, cleared by reset
// - Substitution always accepted, freezes process position
// - Movement not started at timer expiry flags error
// - Too long in intermediate position flags error
// - Early-released pulse never exceeds pulse length
// - Pulse ends on first of three events
// - Bad start position: pulse ends at length only
// - Same position, early release: ends at movement timer
// - Same position, no early release: full length
// - Operation counter, cleared by input or remote
// - Drive only when allowed, else report cause
// - Latest error cause presented as integer
`timescale 1ns/10ps
module swc_switch_ctrl_fn import swc_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire swc_apb_req_t apb_req,
    output swc_apb_rsp_t apb_rsp,
    input wire logic function_block_in,
    input wire logic local_remote_sel,
    input wire logic open_cmd_in,
    input wire logic close_cmd_in,
    input wire logic open_inhibit_in,
    input wire logic close_inhibit_in,
    input wire logic update_inhibit_in,
    input wire logic io_open_ind,
    input wire logic io_closed_ind,
    input wire logic count_clear,
    output swc_out_t ind,
    output logic [15:0] operation_count,
    output logic [3:0] last_cause
);
    swc_state_t s_ff;
    swc_state_t nxt_s;
    logic acc;
    logic wr_done;
    logic mapped;
    logic [15:0] wval;
    swc_ctrl_t wctrl;
    logic req_open;
    logic req_close;
    logic accept;
    logic [1:0] raw;
    logic [1:0] target;
    logic pexp;
    logic mexp;
    logic left;
    logic reach;
    logic fin;
    logic hide_now;
    logic frozen;
    swc_ctrl_t rctrl;
    swc_stat_t rstat;

    always_comb begin
        nxt_s = s_ff;
        raw = {io_closed_ind, io_open_ind};
        // Millisecond tick shared by all timers
        nxt_s.tick = 1'b0;
        if (s_ff.tick_cnt == 18'(TICK_CYCLES - 1)) begin
            nxt_s.tick_cnt = '0;
            nxt_s.tick = 1'b1;
        end else begin
            nxt_s.tick_cnt = s_ff.tick_cnt + 18'h00001;
        end

        // Bus slave: one wait cycle, write lands with pready
        acc = apb_req.psel & apb_req.penable;
        wr_done = acc & s_ff.rsp.pready & apb_req.pwrite;
        wctrl = swc_ctrl_t'(apb_req.pwdata);
        wval = (apb_req.pwdata[15:0] > MS_MAX) ? MS_MAX
            : apb_req.pwdata[15:0];
        mapped = apb_req.paddr inside {OFS_CTRL, OFS_MOVE, OFS_MID,
            OFS_OPUL, OFS_CPUL, OFS_STAT, OFS_CNT};
        rctrl = '0;
        rctrl.early_release_en = s_ff.early;
        rctrl.mid_hide_en = s_ff.hide;
        rctrl.sub_en = s_ff.sub_en;
        rctrl.sub_open = s_ff.sub_pos[0];
        rctrl.sub_closed = s_ff.sub_pos[1];
        rstat = '0;
        rstat.cause = s_ff.cause;
        rstat.ind = s_ff.o;
        nxt_s.rsp.pready = acc & ~s_ff.rsp.pready;
        nxt_s.rsp.pslverr = acc & ~s_ff.rsp.pready & ~mapped;
        nxt_s.rsp.prdata = '0;
        if (acc && !s_ff.rsp.pready && !apb_req.pwrite) begin
            case (apb_req.paddr)
                OFS_CTRL: nxt_s.rsp.prdata = 32'(rctrl);
                OFS_MOVE: nxt_s.rsp.prdata = {16'h0000, s_ff.move_len};
                OFS_MID: nxt_s.rsp.prdata = {16'h0000, s_ff.mid_len};
                OFS_OPUL: nxt_s.rsp.prdata = {16'h0000, s_ff.open_len};
                OFS_CPUL: nxt_s.rsp.prdata = {16'h0000, s_ff.close_len};
                OFS_STAT: nxt_s.rsp.prdata = 32'(rstat);
                OFS_CNT: nxt_s.rsp.prdata = {16'h0000, s_ff.count};
                default: nxt_s.rsp.prdata = '0;
            endcase
        end
        req_open = open_cmd_in;
        req_close = close_cmd_in;
        if (wr_done) begin
            case (apb_req.paddr)
                OFS_CTRL: begin
                    nxt_s.early = wctrl.early_release_en;
                    nxt_s.hide = wctrl.mid_hide_en;
                    nxt_s.sub_en = wctrl.sub_en;
                    nxt_s.sub_pos = {wctrl.sub_closed, wctrl.sub_open};
                    req_open = req_open | wctrl.open_cmd;
                    req_close = req_close | wctrl.close_cmd;
                end
                OFS_MOVE: nxt_s.move_len = wval;
                OFS_MID: nxt_s.mid_len = wval;
                OFS_OPUL: nxt_s.open_len = wval;
                OFS_CPUL: nxt_s.close_len = wval;
                default: ;
            endcase
        end

        // Position reporting, intermediate supervision
        frozen = update_inhibit_in | s_ff.sub_en;
        if (frozen || raw != POS_MID) begin
            nxt_s.mid_ms = '0;
        end else if (s_ff.mid_ms >= s_ff.mid_len) begin
            if (!s_ff.mid_err) begin
                nxt_s.mid_err = 1'b1;
                nxt_s.cause = CAUSE_MID;
            end
        end else if (s_ff.tick) begin
            nxt_s.mid_ms = s_ff.mid_ms + 16'h0001;
        end
        if (frozen) begin
            nxt_s.mid_err = 1'b0;
        end
        hide_now = s_ff.hide & (raw == POS_MID)
            & (s_ff.mid_ms < s_ff.mid_len);
        if (s_ff.sub_en) begin
            nxt_s.rep_pos = s_ff.sub_pos;
        end else if (!update_inhibit_in && !hide_now) begin
            nxt_s.rep_pos = raw;
        end

        // Command acceptance, causes in order of precedence
        accept = 1'b0;
        target = req_open ? POS_OPEN : POS_CLOSED;
        if (req_open || req_close) begin
            if (function_block_in) begin
                nxt_s.cause = CAUSE_FUNC;
            end else if (local_remote_sel) begin
                nxt_s.cause = CAUSE_LOCAL;
            end else if (req_open && open_inhibit_in) begin
                nxt_s.cause = CAUSE_OPEN_INH;
            end else if (!req_open && close_inhibit_in) begin
                nxt_s.cause = CAUSE_CLOSE_INH;
            end else if (s_ff.mode != SWC_IDLE) begin
                nxt_s.cause = CAUSE_BUSY;
            end else begin
                accept = 1'b1;
            end
        end

        // Drive pulse and movement supervision
        pexp = s_ff.pulse_ms >= s_ff.plen;
        mexp = s_ff.move_ms >= s_ff.move_len;
        left = raw != s_ff.start_pos;
        reach = raw == (s_ff.dir_close ? POS_CLOSED : POS_OPEN);
        fin = 1'b0;
        case (s_ff.mode)
            SWC_IDLE: begin
                if (accept) begin
                    nxt_s.mode = SWC_DRIVE;
                    nxt_s.drive = 1'b1;
                    nxt_s.dir_close = ~req_open;
                    nxt_s.plen = req_open ? s_ff.open_len
                        : s_ff.close_len;
                    nxt_s.start_pos = raw;
                    nxt_s.same_pos = raw == target;
                    nxt_s.bad_start = raw == POS_BAD;
                    nxt_s.pulse_ms = '0;
                    nxt_s.move_ms = '0;
                    nxt_s.move_err = 1'b0;
                end
            end
            SWC_DRIVE: begin
                if (s_ff.tick) begin
                    nxt_s.pulse_ms = s_ff.pulse_ms + 16'h0001;
                    nxt_s.move_ms = s_ff.move_ms + 16'h0001;
                end
                if (s_ff.bad_start) begin
                    fin = pexp;
                end else if (s_ff.same_pos) begin
                    fin = pexp | (s_ff.early & mexp);
                end else begin
                    fin = pexp | (s_ff.early & reach)
                        | (mexp & ~left);
                    if (mexp && !left) begin
                        nxt_s.move_err = 1'b1;
                        nxt_s.cause = CAUSE_MOVE;
                    end
                end
                if (fin) begin
                    nxt_s.mode = SWC_IDLE;
                    nxt_s.drive = 1'b0;
                end
            end
            default: begin
                nxt_s.mode = SWC_IDLE;
                nxt_s.drive = 1'b0;
            end
        endcase

        // Counter: an operation in the clearing cycle survives
        if (count_clear || (wr_done && apb_req.paddr == OFS_CTRL
            && wctrl.count_clear)) begin
            nxt_s.count = {15'h0000, accept};
        end else if (accept) begin
            nxt_s.count = s_ff.count + 16'h0001;
        end

        // Outputs, silenced by function block
        nxt_s.o = '0;
        if (!function_block_in) begin
            nxt_s.o.open_drive = nxt_s.drive & ~nxt_s.dir_close;
            nxt_s.o.close_drive = nxt_s.drive & nxt_s.dir_close;
            nxt_s.o.is_open = nxt_s.rep_pos[0];
            nxt_s.o.is_closed = nxt_s.rep_pos[1];
            nxt_s.o.open_inhibited = open_inhibit_in;
            nxt_s.o.close_inhibited = close_inhibit_in;
            nxt_s.o.update_inhibited = update_inhibit_in;
            nxt_s.o.substituted_flag = nxt_s.sub_en;
            nxt_s.o.move_err = nxt_s.move_err;
            nxt_s.o.mid_err = nxt_s.mid_err;
        end

        if (!rst_n) begin
            nxt_s = '0;
            nxt_s.move_len = MOVE_RST;
            nxt_s.mid_len = MID_RST;
            nxt_s.open_len = PULSE_RST;
            nxt_s.close_len = PULSE_RST;
            nxt_s.early = EARLY_RST;
            nxt_s.hide = HIDE_RST;
            nxt_s.cause = CAUSE_NONE;
        end
    end

    always_ff @(posedge clk) begin
        s_ff <= nxt_s;
    end

    assign apb_rsp = s_ff.rsp;
    assign ind = s_ff.o;
    assign operation_count = s_ff.count;
    assign last_cause = s_ff.cause;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    drive_excl_a: assert property (
        !(ind.open_drive && ind.close_drive))
        else $error("both drives active");
    block_quiet_a: assert property (
        function_block_in |=> !ind.open_drive && !ind.close_drive)
        else $error("drive while function blocked");
    local_reject_a: assert property (
        s_ff.mode == SWC_IDLE && open_cmd_in && local_remote_sel
        && !function_block_in
        |=> s_ff.mode == SWC_IDLE && last_cause == CAUSE_LOCAL)
        else $error("command taken in local mode");
    open_inh_a: assert property (
        s_ff.mode == SWC_IDLE && open_cmd_in && open_inhibit_in
        && !local_remote_sel && !function_block_in
        |=> s_ff.mode == SWC_IDLE && last_cause == CAUSE_OPEN_INH
        && ind.open_inhibited)
        else $error("open not inhibited");
    close_inh_a: assert property (
        s_ff.mode == SWC_IDLE && close_cmd_in && !open_cmd_in
        && close_inhibit_in && !local_remote_sel && !function_block_in
        |=> s_ff.mode == SWC_IDLE && last_cause == CAUSE_CLOSE_INH)
        else $error("close not inhibited");
    cmd_start_a: assert property (
        s_ff.mode == SWC_IDLE && open_cmd_in && !open_inhibit_in
        && !local_remote_sel && !function_block_in
        |=> s_ff.mode == SWC_DRIVE && s_ff.move_ms == 16'h0000
        ##1 ind.open_drive)
        else $error("accepted open did not drive");
    pulse_cap_a: assert property (
        s_ff.mode == SWC_DRIVE |-> s_ff.pulse_ms <= s_ff.plen)
        else $error("pulse exceeded its length");
    bad_hold_a: assert property (
        s_ff.mode == SWC_DRIVE && s_ff.bad_start
        && s_ff.pulse_ms < s_ff.plen |=> s_ff.mode == SWC_DRIVE)
        else $error("bad start pulse ended early");
    move_err_a: assert property (
        s_ff.mode == SWC_DRIVE && !s_ff.bad_start && !s_ff.same_pos
        && s_ff.move_ms >= s_ff.move_len && raw == s_ff.start_pos
        |=> s_ff.move_err && s_ff.mode == SWC_IDLE)
        else $error("missing start-of-movement error");
    count_clr_a: assert property (
        count_clear && !accept |=> operation_count == 16'h0000)
        else $error("counter not cleared");
    tick_a: assert property (
        s_ff.tick |-> s_ff.tick_cnt == 18'h00000)
        else $error("tick out of phase");
    mid_err_a: assert property (
        !update_inhibit_in && !s_ff.sub_en && raw == POS_MID
        && s_ff.mid_ms >= s_ff.mid_len |=> s_ff.mid_err)
        else $error("intermediate time error missing");
    frozen_pos_a: assert property (
        update_inhibit_in && !s_ff.sub_en |=> $stable(s_ff.rep_pos))
        else $error("position updated while inhibited");
    sub_show_a: assert property (
        s_ff.sub_en |=> s_ff.rep_pos == $past(s_ff.sub_pos))
        else $error("substituted position not shown");
    same_full_a: assert property (
        s_ff.mode == SWC_DRIVE && s_ff.same_pos && !s_ff.early && !pexp
        |=> s_ff.mode == SWC_DRIVE)
        else $error("same position pulse ended early");

    open_run_c: cover property (ind.open_drive ##1 !ind.open_drive);
    move_err_c: cover property ($rose(s_ff.move_err));
    mid_err_c: cover property ($rose(s_ff.mid_err));
    early_end_c: cover property (
        s_ff.mode == SWC_DRIVE && s_ff.early && reach && !pexp
        ##1 s_ff.mode == SWC_IDLE);
    bad_start_c: cover property (s_ff.mode == SWC_DRIVE && s_ff.bad_start);
endmodule : swc_switch_ctrl_fn

/* inc/swc_pkg.sv */
package swc_pkg;
    localparam int CLK_NS = 5;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam logic [15:0] MS_MAX = 16'hEA60;
    localparam logic [15:0] MOVE_RST = 16'h0064;
    localparam logic [15:0] MID_RST = 16'h0096;
    localparam logic [15:0] PULSE_RST = 16'h00C8;
    localparam logic EARLY_RST = 1'b0;
    localparam logic HIDE_RST = 1'b1;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MOVE = 8'h04;
    localparam logic [7:0] OFS_MID = 8'h08;
    localparam logic [7:0] OFS_OPUL = 8'h0C;
    localparam logic [7:0] OFS_CPUL = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    localparam logic [7:0] OFS_CNT = 8'h18;
    localparam logic [1:0] POS_MID = 2'h0;
    localparam logic [1:0] POS_OPEN = 2'h1;
    localparam logic [1:0] POS_CLOSED = 2'h2;
    localparam logic [1:0] POS_BAD = 2'h3;
    localparam logic [3:0] CAUSE_NONE = 4'h0;
    localparam logic [3:0] CAUSE_FUNC = 4'h1;
    localparam logic [3:0] CAUSE_LOCAL = 4'h2;
    localparam logic [3:0] CAUSE_OPEN_INH = 4'h3;
    localparam logic [3:0] CAUSE_CLOSE_INH = 4'h4;
    localparam logic [3:0] CAUSE_BUSY = 4'h5;
    localparam logic [3:0] CAUSE_MOVE = 4'h6;
    localparam logic [3:0] CAUSE_MID = 4'h7;

    typedef enum logic {SWC_IDLE, SWC_DRIVE} swc_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } swc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } swc_apb_rsp_t;

    typedef struct packed {
        logic [20:0] rsv;
        logic close_cmd;
        logic open_cmd;
        logic count_clear;
        logic [2:0] rsv2;
        logic sub_closed;
        logic sub_open;
        logic sub_en;
        logic mid_hide_en;
        logic early_release_en;
    } swc_ctrl_t;

    typedef struct packed {
        logic open_drive;
        logic close_drive;
        logic is_open;
        logic is_closed;
        logic open_inhibited;
        logic close_inhibited;
        logic update_inhibited;
        logic substituted_flag;
        logic move_err;
        logic mid_err;
    } swc_out_t;

    typedef struct packed {
        logic [15:0] rsv;
        logic [3:0] cause;
        logic [1:0] rsv2;
        swc_out_t ind;
    } swc_stat_t;

    typedef struct packed {
        logic [17:0] tick_cnt;
        logic tick;
        swc_mode_t mode;
        logic dir_close;
        logic same_pos;
        logic bad_start;
        logic [1:0] start_pos;
        logic [15:0] plen;
        logic [15:0] pulse_ms;
        logic [15:0] move_ms;
        logic [15:0] mid_ms;
        logic [15:0] move_len;
        logic [15:0] mid_len;
        logic [15:0] open_len;
        logic [15:0] close_len;
        logic drive;
        logic [1:0] rep_pos;
        logic [1:0] sub_pos;
        logic sub_en;
        logic early;
        logic hide;
        logic move_err;
        logic mid_err;
        logic [15:0] count;
        logic [3:0] cause;
        swc_apb_rsp_t rsp;
        swc_out_t o;
    } swc_state_t;
endpackage : swc_pkg

/* verification/swc_apparatus.sv */
`timescale 1ns/10ps
module swc_apparatus import swc_pkg::*; #(
    parameter int STEP = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic open_drive,
    input wire logic close_drive,
    input wire logic [1:0] mode,
    output logic io_open_ind,
    output logic io_closed_ind
);
    // Mode 1 never moves, 2 halts in mid travel, 3 shows both ends
    logic [1:0] pos_ff;
    logic [1:0] goal_ff;
    int cnt_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pos_ff <= POS_OPEN;
            goal_ff <= POS_OPEN;
            cnt_ff <= 0;
        end else if (cnt_ff == 0) begin
            if (mode != 2'h1 && open_drive && pos_ff != POS_OPEN) begin
                goal_ff <= POS_OPEN;
                cnt_ff <= 2 * STEP;
            end else if (mode != 2'h1 && close_drive
                    && pos_ff != POS_CLOSED) begin
                goal_ff <= POS_CLOSED;
                cnt_ff <= 2 * STEP;
            end
        end else if (cnt_ff != 1 || mode != 2'h2) begin
            cnt_ff <= cnt_ff - 1;
            if (cnt_ff == STEP) pos_ff <= POS_MID;
            if (cnt_ff == 1) pos_ff <= goal_ff;
        end
    end
    assign io_open_ind = pos_ff == POS_OPEN || mode == 2'h3;
    assign io_closed_ind = pos_ff == POS_CLOSED || mode == 2'h3;
endmodule : swc_apparatus

/* verification/swc_switch_ctrl_fn_tb.sv */
`timescale 1ns/10ps
module swc_switch_ctrl_fn_tb import swc_pkg::*; ;
    localparam int T = 4;
    typedef struct packed {
        logic [3:0] blk;
        logic dir;
        logic [7:0] len;
        logic [3:0] cause;
    } swc_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    swc_apb_req_t apb_req = '0;
    swc_apb_rsp_t apb_rsp;
    logic function_block_in = 1'b0, local_remote_sel = 1'b0;
    logic open_cmd_in = 1'b0, close_cmd_in = 1'b0, count_clear = 1'b0;
    logic open_inhibit_in = 1'b0, close_inhibit_in = 1'b0;
    logic update_inhibit_in = 1'b0;
    logic io_open_ind, io_closed_ind, hid, e;
    logic [1:0] mode = 2'h0;
    logic [3:0] b;
    logic [31:0] r;
    swc_out_t ind;
    logic [15:0] operation_count;
    logic [3:0] last_cause;
    int err_total = 0, checks = 0, cyc = 0, n = 0, cnt = 0;
    // Blockers {function, local, open, close}, direction, pulse ms, cause
    swc_row_t rows [9] = '{
        '{4'h8, 1'b0, 8'h00, CAUSE_FUNC},
        '{4'h4, 1'b0, 8'h00, CAUSE_LOCAL},
        '{4'h4, 1'b1, 8'h00, CAUSE_LOCAL},
        '{4'h2, 1'b0, 8'h00, CAUSE_OPEN_INH},
        '{4'h1, 1'b1, 8'h00, CAUSE_CLOSE_INH},
        '{4'h2, 1'b1, 8'hC8, CAUSE_CLOSE_INH},
        '{4'h1, 1'b0, 8'hC8, CAUSE_CLOSE_INH},
        '{4'h0, 1'b1, 8'hC8, CAUSE_CLOSE_INH},
        '{4'h0, 1'b0, 8'hC8, CAUSE_CLOSE_INH}
    };
    logic [7:0] ra [7] = '{OFS_CTRL, OFS_MOVE, OFS_MID, OFS_OPUL, OFS_CPUL,
        OFS_CNT, 8'h1C};
    logic [31:0] rv [7] = '{32'h2, 32'h64, 32'h96, 32'hC8, 32'hC8, 32'h0,
        32'h0};
    logic [7:0] wa [4] = '{OFS_MOVE, OFS_MID, OFS_OPUL, OFS_CPUL};
    logic [31:0] wv [4] = '{32'h5, 32'h6, 32'h8, 32'hA};
    swc_switch_ctrl_fn #(.TICK_CYCLES(T)) swc_switch_ctrl_fn_inst (.clk,
        .rst_n, .apb_req, .apb_rsp, .function_block_in, .local_remote_sel,
        .open_cmd_in, .close_cmd_in, .open_inhibit_in, .close_inhibit_in,
        .update_inhibit_in, .io_open_ind, .io_closed_ind, .count_clear,
        .ind, .operation_count, .last_cause);
    swc_apparatus #(.STEP(8)) swc_apparatus_inst (.clk, .rst_n,
        .open_drive(ind.open_drive), .close_drive(ind.close_drive), .mode,
        .io_open_ind, .io_closed_ind);
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] exp,
            input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s exp %0h got %0h", nm, exp, got);
        end
    endtask : chk
    task automatic span(input string nm, input int c, input int l);
        chk(nm, 1'b1, c >= (l - 1) * T && c <= (l + 1) * T + 4);
    endtask : span
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] rd, output logic er);
        @(posedge clk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        er = apb_rsp.pslverr;
        apb_req <= '0;
    endtask : apb
    task automatic pulse(input logic dir);
        @(posedge clk);
        if (dir) close_cmd_in <= 1'b1;
        else open_cmd_in <= 1'b1;
        @(posedge clk);
        close_cmd_in <= 1'b0;
        open_cmd_in <= 1'b0;
    endtask : pulse
    function automatic logic drv(input logic dir);
        return dir ? ind.close_drive : ind.open_drive;
    endfunction : drv
    // Counts drive cycles and notes any intermediate position shown on the way
    task automatic op(input logic dir, output int c, output logic mid);
        int w;
        w = 0;
        c = 0;
        mid = 1'b0;
        pulse(dir);
        while (drv(dir) !== 1'b1 && w < 8) begin
            @(negedge clk);
            w++;
        end
        while (drv(dir) === 1'b1 && c < 1000) begin
            @(negedge clk);
            c++;
            if (!ind.is_open && !ind.is_closed) mid = 1'b1;
        end
        repeat (12) @(negedge clk);
    endtask : op
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            b = rows[i].blk;
            @(posedge clk);
            {function_block_in, local_remote_sel, open_inhibit_in,
                close_inhibit_in} <= b;
            op(rows[i].dir, n, hid);
            chk("cause", rows[i].cause, last_cause);
            chk("drive", rows[i].len != 0, n != 0);
            chk("inh", b[3] ? 2'h0 : b[1:0], ind[5:4]);
            if (b[3]) chk("blocked", 32'h0, ind);
            if (rows[i].len != 0) begin
                span("pulse", n, rows[i].len);
                cnt++;
            end
        end
        chk("count", cnt, operation_count);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("rst", 32'h0, {ind, operation_count, last_cause});
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 32'h0, r, e);
            chk("rdata", rv[i], r);
            chk("slverr", i == 6, e);
        end
        apb(1'b1, OFS_MOVE, 32'hFFFF, r, e);
        apb(1'b0, OFS_MOVE, 32'h0, r, e);
        chk("clamp", 32'hEA60, r);
        foreach (wa[i]) apb(1'b1, wa[i], wv[i], r, e);
        apb(1'b1, OFS_CTRL, 32'h3, r, e);
        op(1'b1, n, hid);
        chk("early", 1'b1, n >= 16 && n < 9 * T);
        chk("hidden", 1'b0, hid);
        op(1'b1, n, hid);
        span("same_early", n, 5);
        chk("move_err", 1'b0, ind.move_err);
        apb(1'b1, OFS_CTRL, 32'h2, r, e);
        op(1'b1, n, hid);
        span("same_full", n, 10);
        apb(1'b1, OFS_CTRL, 32'h3, r, e);
        mode <= 2'h1;
        op(1'b0, n, hid);
        span("stuck", n, 5);
        chk("move_err", 1'b1, ind.move_err);
        chk("cause", CAUSE_MOVE, last_cause);
        @(posedge clk);
        mode <= 2'h3;
        fork
            op(1'b0, n, hid);
            begin
                repeat (8) @(posedge clk);
                pulse(1'b1);
            end
        join
        span("bad", n, 8);
        chk("cause", CAUSE_BUSY, last_cause);
        @(posedge clk);
        mode <= 2'h2;
        op(1'b1, n, hid);
        chk("mid_err", 1'b1, ind.mid_err);
        chk("cause", CAUSE_MID, last_cause);
        chk("mid_shown", 2'h0, ind[7:6]);
        @(posedge clk);
        update_inhibit_in <= 1'b1;
        mode <= 2'h0;
        repeat (20) @(negedge clk);
        chk("frozen", 3'h1, {ind[7:6], ind.update_inhibited});
        chk("mid_err", 1'b0, ind.mid_err);
        @(posedge clk);
        update_inhibit_in <= 1'b0;
        repeat (6) @(negedge clk);
        chk("thawed", 1'b1, ind.is_closed);
        apb(1'b1, OFS_CTRL, 32'hE, r, e);
        repeat (4) @(negedge clk);
        chk("subst", 3'h5, {ind[7:6], ind.substituted_flag});
        chk("count", 32'h6, operation_count);
        @(posedge clk);
        count_clear <= 1'b1;
        @(posedge clk);
        count_clear <= 1'b0;
        repeat (2) @(negedge clk);
        chk("cleared", 32'h0, operation_count);
        apb(1'b1, OFS_CTRL, 32'h2, r, e);
        op(1'b0, n, hid);
        chk("count", 32'h1, operation_count);
        apb(1'b1, OFS_CTRL, 32'h102, r, e);
        apb(1'b0, OFS_CNT, 32'h0, r, e);
        chk("remote_clr", 32'h0, r);
        apb(1'b1, OFS_CTRL, 32'h402, r, e);
        apb(1'b0, OFS_STAT, 32'h0, r, e);
        chk("stat", {16'h0000, CAUSE_MID, 2'h0, 10'h180}, r);
        chk("count", 32'h1, operation_count);
        print_verdict();
    end
endmodule : swc_switch_ctrl_fn_tb
